// ### dnc_consts.svh
`ifndef DNC_CONSTS_SVH
`define DNC_CONSTS_SVH

// register indices and byte addresses (byte address is four times the index)
`define DNC_IDX_CTRL      12'h200
`define DNC_IDX_STAT      12'h201
`define DNC_IDX_BIND      12'h216
`define DNC_IDX_RDIV      12'h217
`define DNC_IDX_SYNC      12'h219
`define DNC_ADDR_CTRL     (`DNC_IDX_CTRL * 12'h004)
`define DNC_ADDR_STAT     (`DNC_IDX_STAT * 12'h004)
`define DNC_ADDR_BIND     (`DNC_IDX_BIND * 12'h004)
`define DNC_ADDR_RDIV     (`DNC_IDX_RDIV * 12'h004)
`define DNC_ADDR_SYNC     (`DNC_IDX_SYNC * 12'h004)

// reset values
`define DNC_RST_CTRL      8'h00
`define DNC_RST_BIND      8'h02
`define DNC_RST_RDIV      16'h0000
`define DNC_RST_SYNC      8'h02

// field positions
`define DNC_BIT_BIND_A    0
`define DNC_BIT_BIND_B    1
`define DNC_BIT_SYNC_NEXT 0
`define DNC_BIT_SYNC_ILA  1
`define DNC_BIT_CTRL_LINK 0
`define DNC_BIT_CTRL_CAL  1
`define DNC_BIT_CTRL_PDA  2
`define DNC_BIT_CTRL_PDB  3
`define DNC_BIT_CTRL_SGL  4
`define DNC_BIT_STAT_OFFA 0
`define DNC_BIT_STAT_OFFB 1
`define DNC_BIT_STAT_ARM  2
`define DNC_BIT_STAT_UNSF 3
`define DNC_BIT_STAT_SGLF 4

`endif

// ### dnc_pkg.sv
package dnc_pkg;

  typedef enum logic [2:0]
  {
    DNC_ST_IDLE  = 3'b001,
    DNC_ST_ARMED = 3'b010,
    DNC_ST_SPENT = 3'b100
  } dnc_arm_state_e;

  typedef logic [11:0] dnc_sample_t;

endpackage : dnc_pkg

// ### dnc_sync_if.sv
`timescale 1ns/100ps

interface dnc_sync_if;
  logic ila_sel;
  logic arm_bit;
  logic sysref_in;
  logic ila_start;
  logic phase_init;
  logic armed;

  modport regs
  (
    output ila_sel,
    output arm_bit,
    output sysref_in,
    output ila_start,
    input  phase_init,
    input  armed
  );

  modport sync
  (
    input  ila_sel,
    input  arm_bit,
    input  sysref_in,
    input  ila_start,
    output phase_init,
    output armed
  );
endinterface : dnc_sync_if

// ### dnc_nco_phase_alignment_control.sv
`timescale 1ns/100ps

module dnc_nco_phase_alignment_control
(
  input  wire logic  ref_clk,
  input  wire logic  srst,
  dnc_sync_if.sync   sif
);

  dnc_pkg::dnc_arm_state_e state_r;
  dnc_pkg::dnc_arm_state_e state_nxt;
  logic                    arm_prev_r;
  logic                    sysref_prev_r;
  logic                    phase_init_r;
  logic                    phase_init_nxt;

  wire arm_rise    = sif.arm_bit & ~arm_prev_r;
  wire sysref_rise = sif.sysref_in & ~sysref_prev_r;
  wire is_armed    = (state_r == dnc_pkg::DNC_ST_ARMED);

  // arming needs the bit to go 0 then 1; one sysref edge spends it
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      dnc_pkg::DNC_ST_IDLE:
      begin
        if (arm_rise)
          state_nxt = dnc_pkg::DNC_ST_ARMED;
      end
      dnc_pkg::DNC_ST_ARMED:
      begin
        if (sysref_rise)
          state_nxt = dnc_pkg::DNC_ST_SPENT;
        else if (!sif.arm_bit)
          state_nxt = dnc_pkg::DNC_ST_IDLE;
      end
      dnc_pkg::DNC_ST_SPENT:
      begin
        if (!sif.arm_bit)
          state_nxt = dnc_pkg::DNC_ST_IDLE;
      end
      default:
        state_nxt = dnc_pkg::DNC_ST_IDLE;
    endcase
  end

  // phase start on armed sysref edge or, with the ila select bit set, on lane sequence start
  assign phase_init_nxt = (is_armed & sysref_rise) | (sif.ila_sel & sif.ila_start);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_r       <= dnc_pkg::DNC_ST_IDLE;
      arm_prev_r    <= 1'b0;
      sysref_prev_r <= 1'b0;
      phase_init_r  <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      arm_prev_r    <= sif.arm_bit;
      sysref_prev_r <= sif.sysref_in;
      phase_init_r  <= phase_init_nxt;
    end
  end

  assign sif.phase_init = phase_init_r;
  assign sif.armed      = is_armed;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_arm_written;
    !sif.arm_bit ##1 sif.arm_bit;
  endsequence

  sequence s_sysref_edge;
    !sif.sysref_in ##1 sif.sysref_in;
  endsequence

  a_ila_phase_init: assert property (sif.ila_sel && sif.ila_start |=> sif.phase_init)
    else $error("lane sequence start did not start nco phase");

  a_armed_sysref_init: assert property (sif.armed && sif.arm_bit && !sif.sysref_in ##1 (sif.arm_bit && sif.sysref_in)
                                        |=> sif.phase_init)
    else $error("armed sysref edge did not start nco phase");

  a_arm_after_zero: assert property (s_arm_written |=> sif.armed)
    else $error("zero then one on arm bit did not arm");

  a_spent_ignores_edge: assert property ((state_r == dnc_pkg::DNC_ST_SPENT) && !sif.ila_sel ##0 s_sysref_edge
                                         |=> !sif.phase_init)
    else $error("spent arm reacted to later sysref edge");

  a_no_arm_without_zero: assert property (sif.arm_bit && $past(sif.arm_bit) && !is_armed |=> !is_armed)
    else $error("arm taken without a zero being written first");

endmodule : dnc_nco_phase_alignment_control

// ### dnc_regs.sv
`timescale 1ns/100ps
`include "dnc_consts.svh"

module dnc_regs
(
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         sysref,
  input  wire logic         lmfc_ila_start,
  input  wire logic [11:0]  core_a_sample,
  input  wire logic [11:0]  core_b_sample,
  output logic      [11:0]  chan_a_sample,
  output logic      [11:0]  chan_b_sample,
  output logic              chan_a_power_down,
  output logic              chan_b_power_down,
  output logic              nco_phase_init,
  output logic      [15:0]  rational_nco_divisor,
  output logic              serial_link_enable,
  output logic              cal_enable,
  output logic              single_channel_mode
);

  logic [7:0]   ctrl_r;
  logic [7:0]   ctrl_nxt;
  logic [7:0]   bind_r;
  logic [7:0]   bind_nxt;
  logic [15:0]  rdiv_r;
  logic [15:0]  rdiv_nxt;
  logic [7:0]   sync_r;
  logic [7:0]   sync_nxt;
  logic         unsafe_r;
  logic         unsafe_nxt;
  logic         pready_r;
  logic [31:0]  prdata_r;
  logic         pslverr_r;
  logic [11:0]  chan_sample_r [2];
  logic [1:0]   chan_off_r;

  dnc_sync_if sif ();

  // address decode
  wire sel_ctrl   = (paddr == `DNC_ADDR_CTRL);
  wire sel_stat   = (paddr == `DNC_ADDR_STAT);
  wire sel_bind   = (paddr == `DNC_ADDR_BIND);
  wire sel_rdiv   = (paddr == `DNC_ADDR_RDIV);
  wire sel_sync   = (paddr == `DNC_ADDR_SYNC);
  wire sel_any    = sel_ctrl | sel_stat | sel_bind | sel_rdiv | sel_sync;
  wire access_req = psel & penable & ~pready_r;
  wire access_end = psel & penable & pready_r;
  wire wr_go      = access_end & pwrite;
  wire wr_ctrl    = wr_go & sel_ctrl & pstrb[0];
  wire wr_stat    = wr_go & sel_stat & pstrb[0];
  wire wr_bind    = wr_go & sel_bind & pstrb[0];
  wire wr_sync    = wr_go & sel_sync & pstrb[0];
  wire wr_rdiv_lo = wr_go & sel_rdiv & pstrb[0];
  wire wr_rdiv_hi = wr_go & sel_rdiv & pstrb[1];

  // control fields
  wire link_en    = ctrl_r[`DNC_BIT_CTRL_LINK];
  wire cal_en     = ctrl_r[`DNC_BIT_CTRL_CAL];
  wire single_md  = ctrl_r[`DNC_BIT_CTRL_SGL];
  wire [1:0] core_pd = {ctrl_r[`DNC_BIT_CTRL_PDB], ctrl_r[`DNC_BIT_CTRL_PDA]};
  wire [1:0] src_sel = {bind_r[`DNC_BIT_BIND_B], bind_r[`DNC_BIT_BIND_A]};

  // flags a source change while link or calibration still runs
  wire unsafe_set = wr_bind & (pwdata[1:0] != src_sel) & (link_en | cal_en);
  wire sgl_fault  = single_md & (bind_r != `DNC_RST_BIND);

  wire [7:0] stat_word = {3'h0,
                          sgl_fault,
                          unsafe_r,
                          sif.armed,
                          chan_off_r[1],
                          chan_off_r[0]};

  // read mux; reserved bits of ctrl, bind and sync come back as written, status reserved bits read zero
  wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_r} :
                       sel_stat ? {24'h000000, stat_word} :
                       sel_bind ? {24'h000000, bind_r} :
                       sel_rdiv ? {16'h0000, rdiv_r} :
                       sel_sync ? {24'h000000, sync_r} :
                                  32'h00000000;

  // next values of software registers
  assign ctrl_nxt        = wr_ctrl ? pwdata[7:0] : ctrl_r;
  assign bind_nxt        = wr_bind ? pwdata[7:0] : bind_r;
  assign sync_nxt        = wr_sync ? pwdata[7:0] : sync_r;
  assign rdiv_nxt[7:0]   = wr_rdiv_lo ? pwdata[7:0] : rdiv_r[7:0];
  assign rdiv_nxt[15:8]  = wr_rdiv_hi ? pwdata[15:8] : rdiv_r[15:8];
  // set wins over a write-one clear
  assign unsafe_nxt      = unsafe_set | (unsafe_r & ~(wr_stat & pwdata[`DNC_BIT_STAT_UNSF]));

  // apb slave: one wait state, answer registered
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= access_req;
      prdata_r  <= (access_req & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr_r <= access_req & ~sel_any;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_r   <= `DNC_RST_CTRL;
      bind_r   <= `DNC_RST_BIND;
      rdiv_r   <= `DNC_RST_RDIV;
      sync_r   <= `DNC_RST_SYNC;
      unsafe_r <= 1'b0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      bind_r   <= bind_nxt;
      rdiv_r   <= rdiv_nxt;
      sync_r   <= sync_nxt;
      unsafe_r <= unsafe_nxt;
    end
  end

  // per channel: pick source core and follow that core's power-down
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_chan
      wire        src_b   = src_sel[ch];
      wire        off_nxt = src_b ? core_pd[1] : core_pd[0];
      wire [11:0] smp_nxt = off_nxt ? 12'h000 : (src_b ? core_b_sample : core_a_sample);

      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          chan_sample_r[ch] <= 12'h000;
          chan_off_r[ch]    <= 1'b0;
        end
        else
        begin
          chan_sample_r[ch] <= smp_nxt;
          chan_off_r[ch]    <= off_nxt;
        end
      end
    end
  endgenerate

  // nco phase alignment
  assign sif.ila_sel   = sync_r[`DNC_BIT_SYNC_ILA];
  assign sif.arm_bit   = sync_r[`DNC_BIT_SYNC_NEXT];
  assign sif.sysref_in = sysref;
  assign sif.ila_start = lmfc_ila_start;

  dnc_nco_phase_alignment_control u_nco_phase_alignment_control
  (
    .ref_clk (ref_clk),
    .srst    (srst),
    .sif     (sif)
  );

  // outputs
  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign chan_a_sample        = chan_sample_r[0];
  assign chan_b_sample        = chan_sample_r[1];
  assign chan_a_power_down    = chan_off_r[0];
  assign chan_b_power_down    = chan_off_r[1];
  assign nco_phase_init       = sif.phase_init;
  assign rational_nco_divisor = rdiv_r;
  assign serial_link_enable   = link_en;
  assign cal_enable           = cal_en;
  assign single_channel_mode  = single_md;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_wait;
    psel && penable && !pready;
  endsequence

  a_reset_values: assert property ($fell(srst) |-> bind_r == 8'h02 && sync_r == 8'h02 && rdiv_r == 16'h0000)
    else $error("register reset values wrong after reset release");

  a_sync_reset_bits: assert property ($fell(srst) |-> sif.ila_sel && !sif.arm_bit)
    else $error("phase alignment control bits wrong after reset");

  a_route_chan_b: assert property (!chan_b_power_down && !$past(srst) |->
                                   chan_b_sample == ($past(bind_r[1]) ? $past(core_b_sample) : $past(core_a_sample)))
    else $error("channel b carries wrong core");

  a_route_chan_a: assert property (!chan_a_power_down && !$past(srst) |->
                                   chan_a_sample == ($past(bind_r[0]) ? $past(core_b_sample) : $past(core_a_sample)))
    else $error("channel a carries wrong core");

  a_chan_pd_follow: assert property (##1 chan_a_power_down == $past(bind_r[0] ? ctrl_r[3] : ctrl_r[2]) &&
                                     chan_b_power_down == $past(bind_r[1] ? ctrl_r[3] : ctrl_r[2]))
    else $error("channel power-down does not follow bound core");

  a_rdiv_write: assert property (s_apb_setup ##1 s_apb_wait ##1 (pready && pwrite && paddr == 12'h85C && pstrb[1:0] == 2'h3)
                                 |=> rational_nco_divisor == $past(pwdata[15:0]))
    else $error("divisor write not taken");

  a_reserved_kept: assert property (wr_bind |=> bind_r == $past(pwdata[7:0]) ##1
                                    (chan_a_power_down == $past(bind_r[0] ? ctrl_r[3] : ctrl_r[2])))
    else $error("reserved bits not kept or steer routing");

  a_apb_one_wait: assert property (s_apb_wait |=> pready ##1 !pready)
    else $error("apb answer not given after one wait state");

  sequence s_stat_read;
    psel && penable && pready && !pwrite && (paddr == 12'h804);
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  a_stat_chan_off: assert property (s_stat_read |->
                                    prdata[1:0] == $past({chan_b_power_down, chan_a_power_down}))
    else $error("status does not show channel power-down");

  a_stat_armed: assert property (s_stat_read |-> prdata[2] == $past(sif.armed))
    else $error("status does not show arm state");

  a_stat_single: assert property (s_stat_read |->
                                  prdata[4] == $past(single_channel_mode && (bind_r != 8'h02)))
    else $error("status does not flag single mode with moved sources");

  a_stat_upper_zero: assert property (s_stat_read |-> prdata[31:5] == 27'h0000000)
    else $error("status upper bits not zero");

  a_unsafe_set: assert property (wr_bind && (serial_link_enable || cal_enable) && (pwdata[1:0] != bind_r[1:0])
                                 |=> unsafe_r)
    else $error("source change under link or calibration not flagged");

  a_unsafe_clear: assert property (unsafe_r && wr_stat && pwdata[3] |=> !unsafe_r)
    else $error("sticky source-change flag not cleared");

  a_unsafe_sticky: assert property (unsafe_r && !wr_stat |=> unsafe_r)
    else $error("sticky source-change flag lost");

  a_unmapped_err: assert property (s_access_done ##0 !(paddr inside {12'h800, 12'h804, 12'h858, 12'h85C, 12'h864})
                                   |-> pslverr && (prdata == 32'h00000000))
    else $error("unmapped access not refused");

  a_mapped_no_err: assert property (s_access_done ##0 (paddr inside {12'h800, 12'h804, 12'h858, 12'h85C, 12'h864})
                                    |-> !pslverr)
    else $error("mapped access refused");

  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error reported outside an answer");

  a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside an answer");

  a_bind_hold: assert property (!wr_bind |=> $stable(bind_r))
    else $error("source select changed without a write");

  a_rdiv_hold: assert property (!(wr_go && sel_rdiv) |=> $stable(rdiv_r))
    else $error("divisor changed without a write");

  a_sync_hold: assert property (!wr_sync |=> $stable(sync_r))
    else $error("phase alignment control changed without a write");

  a_ctrl_write: assert property (wr_ctrl |=> serial_link_enable == $past(pwdata[0]) && cal_enable == $past(pwdata[1])
                                 && single_channel_mode == $past(pwdata[4]))
    else $error("control outputs do not follow control write");

  a_pd_zero_a: assert property (chan_a_power_down |-> chan_a_sample == 12'h000)
    else $error("powered-down channel a carries samples");

  a_pd_zero_b: assert property (chan_b_power_down |-> chan_b_sample == 12'h000)
    else $error("powered-down channel b carries samples");

  a_no_stray_init: assert property (!sif.ila_sel && !sif.armed |=> !nco_phase_init)
    else $error("nco phase started with no trigger enabled");

endmodule : dnc_regs

// ### dnc_regs_tb_top.sv
`timescale 1ns/100ps
`include "dnc_consts.svh"

module dnc_regs_tb_top;
  logic        ref_clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sysref;
  logic        lmfc_ila_start;
  logic [11:0] core_a_sample;
  logic [11:0] core_b_sample;
  logic [11:0] chan_a_sample;
  logic [11:0] chan_b_sample;
  logic        chan_a_power_down;
  logic        chan_b_power_down;
  logic        nco_phase_init;
  logic [15:0] rational_nco_divisor;
  logic        serial_link_enable;
  logic        cal_enable;
  logic        single_channel_mode;
  int          num_errors;
  int          checks;
  int          bind_m;
  int          pda_m;
  int          pdb_m;
  logic [31:0] r;
  logic [7:0]  v;
  logic [31:0] rd;
  logic        err;

  dnc_regs dut
  (
    .ref_clk (ref_clk), .srst (srst), .psel (psel), .penable (penable), .pwrite (pwrite),
    .paddr (paddr), .pwdata (pwdata), .pstrb (pstrb), .prdata (prdata), .pready (pready),
    .pslverr (pslverr), .sysref (sysref), .lmfc_ila_start (lmfc_ila_start),
    .core_a_sample (core_a_sample), .core_b_sample (core_b_sample),
    .chan_a_sample (chan_a_sample), .chan_b_sample (chan_b_sample),
    .chan_a_power_down (chan_a_power_down), .chan_b_power_down (chan_b_power_down),
    .nco_phase_init (nco_phase_init), .rational_nco_divisor (rational_nco_divisor),
    .serial_link_enable (serial_link_enable), .cal_enable (cal_enable),
    .single_channel_mode (single_channel_mode)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge ref_clk);
    end
    if (pready !== 1'b1)
    begin
      num_errors++;
      $display("wrong value at %0t: no pready", $time);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, s, q, e);
  endtask : wreg

  task automatic rreg(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask : rreg

  // random samples through the model's binding and power-down
  task automatic route_chk();
    logic [11:0] sa;
    logic [11:0] sb;
    int          pa;
    int          pb;
    sa = 12'($urandom);
    sb = 12'($urandom);
    @(posedge ref_clk);
    core_a_sample <= sa;
    core_b_sample <= sb;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    pa = bind_m[0] ? pdb_m : pda_m;
    pb = bind_m[1] ? pdb_m : pda_m;
    chk(chan_a_power_down, pa);
    chk(chan_b_power_down, pb);
    chk(chan_a_sample, pa ? 12'h000 : (bind_m[0] ? sb : sa));
    chk(chan_b_sample, pb ? 12'h000 : (bind_m[1] ? sb : sa));
  endtask : route_chk

  // one-cycle trigger pulse, then the phase-init pulse is expected or not
  task automatic trig(input logic sel, input logic exp);
    @(posedge ref_clk);
    if (sel)
      sysref <= 1'b1;
    else
      lmfc_ila_start <= 1'b1;
    @(posedge ref_clk);
    sysref         <= 1'b0;
    lmfc_ila_start <= 1'b0;
    @(negedge ref_clk);
    chk(nco_phase_init, exp);
    @(negedge ref_clk);
    chk(nco_phase_init, 1'b0);
  endtask : trig

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    sysref = 1'b0;
    lmfc_ila_start = 1'b0;
    core_a_sample = 12'h000;
    core_b_sample = 12'h000;
    num_errors = 0;
    checks = 0;
    void'($urandom(32'hE8D4));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rreg(`DNC_ADDR_BIND, 32'h02);
    rreg(`DNC_ADDR_RDIV, 32'h0);
    rreg(`DNC_ADDR_SYNC, 32'h02);
    apb(1'b0, 12'h004, 32'h0, 4'h0, rd, err);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    $display("test reset_and_map done");
    for (int i = 0; i < 16; i++)
    begin
      bind_m = i % 4;
      pda_m = (i / 4) % 2;
      pdb_m = i / 8;
      r = $urandom;
      v = {r[7:2], 2'(bind_m)};
      wreg(`DNC_ADDR_BIND, {r[31:8], v}, 4'hF);
      wreg(`DNC_ADDR_CTRL, {28'h0, pdb_m[0], pda_m[0], 2'b00}, 4'hF);
      rreg(`DNC_ADDR_BIND, {24'h0, v});
      route_chk();
      rreg(`DNC_ADDR_STAT, 32'((bind_m[1] ? pdb_m : pda_m) * 2 + (bind_m[0] ? pdb_m : pda_m)));
    end
    wreg(`DNC_ADDR_CTRL, 32'h0, 4'hF);
    wreg(`DNC_ADDR_BIND, 32'h02, 4'hF);
    $display("test routing done");
    wreg(`DNC_ADDR_CTRL, 32'h13, 4'hF);
    @(negedge ref_clk);
    chk(serial_link_enable, 1'b1);
    chk(cal_enable, 1'b1);
    chk(single_channel_mode, 1'b1);
    rreg(`DNC_ADDR_STAT, 32'h00);
    wreg(`DNC_ADDR_BIND, 32'h03, 4'hF);
    rreg(`DNC_ADDR_STAT, 32'h18);
    wreg(`DNC_ADDR_STAT, 32'h08, 4'hF);
    rreg(`DNC_ADDR_STAT, 32'h10);
    wreg(`DNC_ADDR_CTRL, 32'h00, 4'hF);
    @(negedge ref_clk);
    chk(serial_link_enable, 1'b0);
    chk(cal_enable, 1'b0);
    chk(single_channel_mode, 1'b0);
    wreg(`DNC_ADDR_BIND, 32'h02, 4'hF);
    rreg(`DNC_ADDR_STAT, 32'h00);
    $display("test status flags done");
    repeat (3)
    begin
      r = $urandom;
      wreg(`DNC_ADDR_RDIV, r, 4'h3);
      rreg(`DNC_ADDR_RDIV, {16'h0, r[15:0]});
      chk(rational_nco_divisor, r[15:0]);
    end
    $display("test divisor done");
    trig(1'b0, 1'b1);
    wreg(`DNC_ADDR_SYNC, 32'h00, 4'hF);
    trig(1'b0, 1'b0);
    trig(1'b1, 1'b0);
    r = $urandom;
    wreg(`DNC_ADDR_SYNC, {24'h0, r[7:2], 2'b01}, 4'hF);
    rreg(`DNC_ADDR_SYNC, {24'h0, r[7:2], 2'b01});
    rreg(`DNC_ADDR_STAT, 32'h04);
    repeat (3) @(posedge ref_clk);
    trig(1'b1, 1'b1);
    trig(1'b1, 1'b0);
    rreg(`DNC_ADDR_STAT, 32'h00);
    wreg(`DNC_ADDR_SYNC, 32'h01, 4'hF);
    repeat (3) @(posedge ref_clk);
    trig(1'b1, 1'b0);
    wreg(`DNC_ADDR_SYNC, 32'h00, 4'hF);
    wreg(`DNC_ADDR_SYNC, 32'h01, 4'hF);
    repeat (3) @(posedge ref_clk);
    trig(1'b1, 1'b1);
    $display("test alignment done");
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk(rational_nco_divisor, 16'h0000);
    chk(nco_phase_init, 1'b0);
    chk(chan_a_power_down, 1'b0);
    chk(chan_a_sample, 12'h000);
    rreg(`DNC_ADDR_BIND, 32'h02);
    rreg(`DNC_ADDR_SYNC, 32'h02);
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : dnc_regs_tb_top
